// file: ebtec_consts.vh
// constants for the eight bit timer/event counter channel
// assumes a single system clock; count clock derived inside the block from the prescaler or from event pin edges
`ifndef EBTEC_CONSTS_VH
`define EBTEC_CONSTS_VH
// register indices on the plain register port
`define EBTEC_ADDR_COUNT   2'h0
`define EBTEC_ADDR_CMP     2'h1
`define EBTEC_ADDR_CLKSEL  2'h2
`define EBTEC_ADDR_MODE    2'h3
// mode control field positions
`define EBTEC_MODE_OE      0
`define EBTEC_MODE_LEVEL   1
`define EBTEC_MODE_CLR     2
`define EBTEC_MODE_SET     3
`define EBTEC_MODE_PWM     6
`define EBTEC_MODE_EN      7
// mode bits that are stored; bits 5,4 and the set/clear actions are not
`define EBTEC_MODE_MASK    8'hC3
// reset values
`define EBTEC_RST_MODE     8'h00
`define EBTEC_RST_CMP      8'h00
`define EBTEC_RST_CLKSEL   3'h0
// clock select codes
`define EBTEC_SEL_EV_FALL  3'h0
`define EBTEC_SEL_EV_RISE  3'h1
`endif

// file: ebtec_timer.v
// one eight bit timer/event counter channel with register port
// assumes event pin is asynchronous; register port is on sys_clk_in
// count clock is a one-cycle tick enable, never a separate clock net
// read data stand for one cycle only and read zero otherwise
// Behaviour
// - clear on match, keep counting, interrupt
// - match period is compare plus one
// - enable bit set starts counting
// - event mode counts selected pin edges
// - select 00H falling, 01H rising
// - event mode match clears and interrupts
// - clock select bits 0..2 pick clock
// - square wave toggles output on match
// - square frequency over twice compare-plus-one
// - set/clear bits force output flip-flop
// - mode bit 6 selects PWM
// - bit 1 selects PWM active level
// - bit 0 enables output pin
// - inactive until overflow, active until match
// - PWM period 256, width compare
// - stop in PWM gives inactive output
// - PWM compare buffered until overflow
// - compare read returns newest write
// - first match may be one clock late
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "ebtec_consts.vh"

module ebtec_timer #(
  parameter DIV_WIDTH = 10
) (
  input  wire       sys_clk_in,
  input  wire       rst_n_in,
  // plain register port
  input  wire [1:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  // far side event pin, asynchronous
  input  wire       event_input_pin_in,
  // all outputs straight from flip-flops
  output reg  [7:0] reg_rdata_out,
  output reg        match_interrupt_request_out,
  output reg        timer_output_pin_out
);

  // software-visible control state
  reg [7:0]           counter_mode_control_reg_r;
  reg [2:0]           count_clock_select_reg_r;

  // compare pair; the active copy lags a write made while pwm runs
  reg [7:0]           compare_value_reg_r;   // value seen by software
  reg [7:0]           compare_active_r;      // value used by the comparator
  reg                 compare_pending_r;

  // counting state and the output flip-flop
  reg [7:0]           event_counter_value_r;
  reg                 out_ff_r;

  // free-running divider behind the internal count clocks
  reg [DIV_WIDTH-1:0] prescale_r;

  // event pin synchroniser and edge memory
  reg                 ev_sync1_r;
  reg                 ev_sync2_r;
  reg                 ev_prev_r;

  wire count_enable_bit     = counter_mode_control_reg_r[`EBTEC_MODE_EN];
  wire pwm_mode_select_bit  = counter_mode_control_reg_r[`EBTEC_MODE_PWM];
  wire invert_or_active_level_bit = counter_mode_control_reg_r[`EBTEC_MODE_LEVEL];
  wire output_enable_bit    = counter_mode_control_reg_r[`EBTEC_MODE_OE];

  // register index decode, shared by every write strobe
  function addr_is;
    input [1:0] addr;
    input [1:0] idx;
    begin
      addr_is = (addr == idx);
    end
  endfunction

  // internal prescaler tap select; code 0 and 1 are pin edges
  // codes 3 to 7 tick on the falling edge of their divider bit, one cycle wide; code 2 ticks every cycle
  function tap_pick;
    input [2:0]           sel;
    input [DIV_WIDTH-1:0] pre;
    input [DIV_WIDTH-1:0] pre_nxt;
    begin
      case (sel)
        3'h2:    tap_pick = 1'b1;
        3'h3:    tap_pick = pre[1] & ~pre_nxt[1];
        3'h4:    tap_pick = pre[3] & ~pre_nxt[3];
        3'h5:    tap_pick = pre[5] & ~pre_nxt[5];
        3'h6:    tap_pick = pre[7] & ~pre_nxt[7];
        default: tap_pick = pre[DIV_WIDTH-1] & ~pre_nxt[DIV_WIDTH-1];
      endcase
    end
  endfunction

  wire [DIV_WIDTH-1:0] prescale_nxt = prescale_r + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
  wire ev_rise = ev_sync2_r & ~ev_prev_r;
  wire ev_fall = ~ev_sync2_r & ev_prev_r;

  reg count_tick;
  // pin edges and divider taps share one tick so counting logic is common
  always @* begin
    if (count_clock_select_reg_r == `EBTEC_SEL_EV_FALL) begin
      count_tick = ev_fall;
    end else if (count_clock_select_reg_r == `EBTEC_SEL_EV_RISE) begin
      count_tick = ev_rise;
    end else begin
      count_tick = tap_pick(count_clock_select_reg_r, prescale_r, prescale_nxt);
    end
  end

  wire match_hit = count_enable_bit & count_tick & ~pwm_mode_select_bit &
                   (event_counter_value_r == compare_active_r);
  wire overflow  = count_enable_bit & count_tick & pwm_mode_select_bit &
                   (event_counter_value_r == 8'hFF);
  // pwm compare match, raises the request only
  wire pwm_match = count_enable_bit & count_tick & pwm_mode_select_bit &
                   (event_counter_value_r == compare_active_r);

  // counter value one tick ahead, wraps in eight bits on purpose
  wire [7:0] count_plus1 = event_counter_value_r + 8'h01;

  // end the phase one tick early so it spans exactly N ticks
  wire pwm_fall  = count_enable_bit & count_tick & pwm_mode_select_bit &
                   (count_plus1 == compare_active_r);

  // compare that governs the phase opened at this overflow
  // a zero taken over at the wrap must keep the pin inactive
  wire [7:0] cmp_next = (overflow && compare_pending_r) ? compare_value_reg_r :
                        compare_active_r;

  // write strobes per register
  wire wr_mode   = reg_wr_in & addr_is(reg_addr_in, `EBTEC_ADDR_MODE);
  wire wr_cmp    = reg_wr_in & addr_is(reg_addr_in, `EBTEC_ADDR_CMP);
  wire wr_clksel = reg_wr_in & addr_is(reg_addr_in, `EBTEC_ADDR_CLKSEL);

  // only the stored mode bits survive a write
  wire [7:0] mode_store = reg_wdata_in & `EBTEC_MODE_MASK;

  // set/clear are write actions; both at once changes nothing
  wire force_set = wr_mode & reg_wdata_in[`EBTEC_MODE_SET] &
                   ~reg_wdata_in[`EBTEC_MODE_CLR];
  wire force_clr = wr_mode & reg_wdata_in[`EBTEC_MODE_CLR] &
                   ~reg_wdata_in[`EBTEC_MODE_SET];

  // event pin two-stage synchroniser, edge from second stage only
  // reset to the pin's idle low level so no false edge follows reset
  // costs three cycles of latency on every event edge
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ev_sync1_r <= 1'b0;
      ev_sync2_r <= 1'b0;
      ev_prev_r  <= 1'b0;
    end else begin
      ev_sync1_r <= event_input_pin_in;
      ev_sync2_r <= ev_sync1_r;
      ev_prev_r  <= ev_sync2_r;
    end
  end

  // free-running prescaler; start is not aligned to it
  // never restarted by software, so the first tick may come late
  // start phase vs count clock
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      prescale_r <= {DIV_WIDTH{1'b0}};
    end else begin
      prescale_r <= prescale_nxt;
    end
  end

  // control registers; set/clear bits are write actions, not stored
  // a clock select change while running takes effect at the next tick
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      counter_mode_control_reg_r <= `EBTEC_RST_MODE;
      count_clock_select_reg_r   <= `EBTEC_RST_CLKSEL;
    end else begin
      if (wr_mode) begin
        counter_mode_control_reg_r <= mode_store;
      end
      if (wr_clksel) begin
        count_clock_select_reg_r <= reg_wdata_in[2:0];
      end
    end
  end

  // buffered compare in PWM mode
  // a write in the overflow cycle wins; the transfer waits a period
  // stopped or non-pwm writes load the comparator at once
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      compare_value_reg_r <= `EBTEC_RST_CMP;
      compare_active_r    <= `EBTEC_RST_CMP;
      compare_pending_r   <= 1'b0;
    end else begin
      if (wr_cmp) begin
        compare_value_reg_r <= reg_wdata_in;
      end
      if (wr_cmp && (!pwm_mode_select_bit || !count_enable_bit)) begin
        compare_active_r  <= reg_wdata_in;
        compare_pending_r <= 1'b0;
      end else if (wr_cmp) begin
        compare_pending_r <= 1'b1;
      end else if (overflow && compare_pending_r) begin
        compare_active_r  <= compare_value_reg_r;
        compare_pending_r <= 1'b0;
      end
    end
  end

  // counter
  // clear-and-start in timer modes, free wrap in pwm mode
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      event_counter_value_r <= 8'h00;
    end else if (!count_enable_bit) begin
      event_counter_value_r <= 8'h00;
    end else if (match_hit) begin
      // clear on match gives N+1 period
      event_counter_value_r <= 8'h00;
    end else if (count_tick) begin
      // free run wraps every 256 ticks
      event_counter_value_r <= event_counter_value_r + 8'h01;
    end
  end

  // interrupt pulse on match, one system clock wide
  // the request is a pulse, software keeps no flag here
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      match_interrupt_request_out <= 1'b0;
    end else begin
      match_interrupt_request_out <= match_hit | pwm_match;
    end
  end

  // output flip-flop: force, toggle, or PWM phase
  // set/clear ignored in pwm mode, where the phase owns the flip-flop
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      out_ff_r <= 1'b0;
    end else if (pwm_mode_select_bit) begin
      if (!count_enable_bit) begin
        // inactive when stopped or before overflow
        out_ff_r <= 1'b0;
      end else if (overflow && cmp_next != 8'h00) begin
        out_ff_r <= 1'b1;
      end else if (pwm_fall) begin
        // active phase ends after N ticks
        out_ff_r <= 1'b0;
      end
    end else if (force_set) begin
      out_ff_r <= 1'b1;
    end else if (force_clr) begin
      out_ff_r <= 1'b0;
    end else if (match_hit && invert_or_active_level_bit) begin
      // toggle per match, half period N+1
      out_ff_r <= ~out_ff_r;
    end
  end

  // pin drive; disabled output reads low
  // in pwm mode the level bit acts at once, whether or not the counter runs
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      timer_output_pin_out <= 1'b0;
    end else if (!output_enable_bit) begin
      timer_output_pin_out <= 1'b0;
    end else if (pwm_mode_select_bit) begin
      timer_output_pin_out <= out_ff_r ^ invert_or_active_level_bit;
    end else begin
      timer_output_pin_out <= out_ff_r;
    end
  end

  // read port, data one cycle after strobe; set/clear read zero
  // compare reads the newest write, not the value in use
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      if (reg_addr_in == `EBTEC_ADDR_COUNT) begin
        reg_rdata_out <= event_counter_value_r;
      end else if (reg_addr_in == `EBTEC_ADDR_CMP) begin
        reg_rdata_out <= compare_value_reg_r;
      end else if (reg_addr_in == `EBTEC_ADDR_CLKSEL) begin
        reg_rdata_out <= {5'h00, count_clock_select_reg_r};
      end else begin
        reg_rdata_out <= counter_mode_control_reg_r;
      end
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

endmodule // ebtec_timer

// file: ebtec_checker.sv
// port-level properties of one timer channel
// assumes it is bound to ebtec_timer and sees only its ports
`timescale 1ns/1ps
module ebtec_checker (
  input wire       sys_clk_in,
  input wire       rst_n_in,
  input wire [1:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire       reg_wr_in,
  input wire       reg_rd_in,
  input wire       event_input_pin_in,
  input wire [7:0] reg_rdata_out,
  input wire       match_interrupt_request_out,
  input wire       timer_output_pin_out
);
  logic [7:0] m_r, c_r;
  logic [2:0] s_r;
  logic [9:0] a_r, g_r;
  logic [3:0] e_r;
  logic       v_r;
  wire        irq = match_interrupt_request_out;
  wire        pin = timer_output_pin_out;
  // shadows of software writes; age saturates so long runs stay usable
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      m_r <= 8'h00;
      c_r <= 8'h00;
      s_r <= 3'h0;
      a_r <= 10'h000;
      g_r <= 10'h000;
      e_r <= 4'hF;
      v_r <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == 2'h3) m_r <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == 2'h1) c_r <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == 2'h2) s_r <= reg_wdata_in[2:0];
      a_r <= reg_wr_in ? 10'h000 : a_r + (a_r != 10'h3FF);
      g_r <= irq ? 10'h001 : g_r + 10'h001;
      e_r <= (v_r != event_input_pin_in) ? 4'h0 : e_r + (e_r != 4'hF);
      v_r <= event_input_pin_in;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_SET_HIGH: assert property (reg_wr_in && reg_addr_in == 2'h3 &&
    reg_wdata_in == 8'h0B |-> ##[1:3] pin) else $error("set bit missed");
  AST_CLR_LOW: assert property (reg_wr_in && reg_addr_in == 2'h3 &&
    reg_wdata_in == 8'h07 |-> ##[1:3] !pin) else $error("clear bit missed");
  AST_OE_OFF: assert property (a_r > 3 && !m_r[0] |-> !pin)
    else $error("pin driven while disabled");
  AST_PWM_IDLE: assert property (a_r > 3 && m_r[6] && !m_r[7] && m_r[0]
    |-> pin == m_r[1]) else $error("stopped pwm not inactive");
  AST_IRQ_RUN: assert property (irq |-> m_r[7] || a_r < 4)
    else $error("match while stopped");
  AST_READBACK: assert property (reg_rd_in && reg_addr_in == 2'h1
    |=> reg_rdata_out == c_r) else $error("compare readback wrong");
  AST_STOP_ZERO: assert property (reg_rd_in && reg_addr_in == 2'h0 &&
    !m_r[7] && a_r > 2 |=> reg_rdata_out == 8'h00) else $error("stopped count not 0");
  AST_EV_EDGE: assert property (irq && m_r[7] && s_r < 3'h2 && a_r > 8
    |-> e_r < 4'h8) else $error("event match without edge");
  AST_PERIOD: assert property (irq && m_r[7] && !m_r[6] && s_r == 3'h2
    && a_r > 300 |-> g_r == c_r + 1) else $error("interval period wrong");
  AST_SQ_TOGGLE: assert property ($changed(pin) && a_r > 3 && m_r[7] &&
    !m_r[6] |-> irq || $past(irq) || $past(irq, 2)) else $error("toggle off match");
  cover property (irq && m_r[6]);
  cover property (irq && s_r < 3'h2);
  cover property (pin && m_r == 8'h83);
endmodule // ebtec_checker
bind ebtec_timer ebtec_checker i_ebtec_checker (.*);

// file: ebtec_event_src.sv
// far-side source of pulses on the event pin
// assumes the bench calls send; pin rests low between bursts
`timescale 1ns/1ps
module ebtec_event_src (
  input  wire  sys_clk_in,
  output logic event_out
);
  initial event_out = 1'b0;
  // eight clocks each level, wide enough for the synchroniser
  task send(input int cnt);
    repeat (cnt) begin
      @(posedge sys_clk_in);
      event_out <= 1'b1;
      repeat (8) @(posedge sys_clk_in);
      event_out <= 1'b0;
      repeat (7) @(posedge sys_clk_in);
    end
  endtask
endmodule // ebtec_event_src

// file: ebtec_timer_bench.sv
// self-checking bench for one timer channel
// assumes ebtec_event_src drives the event pin, checker bound to the design
`timescale 1ns/1ps
module ebtec_timer_bench;
  logic       clk, rst_n, wr, rd, pin, irq, ev;
  logic [1:0] addr;
  logic [7:0] wd, rdata, n;
  int         fails, num_checks, hi, ir, m, k;
  ebtec_timer #(.DIV_WIDTH(4)) i_ebtec_timer (.sys_clk_in(clk), .rst_n_in(rst_n),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
    .event_input_pin_in(ev), .reg_rdata_out(rdata),
    .match_interrupt_request_out(irq), .timer_output_pin_out(pin));
  ebtec_event_src i_ebtec_event_src (.sys_clk_in(clk), .event_out(ev));
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1; addr <= a; wd <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task rd_chk(input string nm, input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1; addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk(nm, rdata, e);
  endtask
  // any window of whole periods holds an exact count
  task meas(input int w);
    hi = 0; ir = 0;
    repeat (w) begin
      @(posedge clk);
      #1 hi += pin; ir += irq;
    end
  endtask
  task wait_pin(input logic v);
    for (int i = 0; i < 600 && pin !== v; i++) @(posedge clk);
  endtask
  task print_verdict;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // watchdog, well beyond the few thousand cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict;
  end
  initial begin
    rst_n = 0; wr = 0; rd = 0; addr = 0; wd = 0;
    k = $urandom(32'h6481);
    repeat (4) @(posedge clk);
    rst_n <= 1;
    for (k = 0; k < 4; k++) rd_chk("reset value", k, 8'h00);
    // interval: largest, random and zero compare, two count clocks
    // compare written only while the counter is stopped
    for (k = 0; k < 3; k++) begin
      m = (k == 0) ? 255 : (k == 1) ? $urandom_range(254) : 0;
      wr_reg(2'h2, (k == 2) ? 8'h03 : 8'h02);
      wr_reg(2'h1, m);
      wr_reg(2'h3, 8'h80);
      repeat (20) @(posedge clk);
      meas(4 * (m + 1) * ((k == 2) ? 4 : 1));
      chk("interval irqs", ir, 4);
      wr_reg(2'h3, 8'h00);
      rd_chk("stopped count", 2'h0, 8'h00);
    end
    // both initial levels, then square wave from the low start level
    m = $urandom_range(60);
    wr_reg(2'h2, 8'h02);
    wr_reg(2'h1, m);
    wr_reg(2'h3, 8'h0B); // high start pattern
    repeat (3) @(posedge clk);
    chk("init high", pin, 1);
    wr_reg(2'h3, 8'h07); // low start pattern
    repeat (3) @(posedge clk);
    chk("init low", pin, 0);
    wr_reg(2'h3, 8'h83);
    repeat (150) @(posedge clk);
    meas(4 * (m + 1));
    chk("square high", hi, 2 * (m + 1));
    chk("square irqs", ir, 4);
    wr_reg(2'h3, 8'h00);
    // event counting on falling then rising edges
    for (k = 0; k < 2; k++) begin
      wr_reg(2'h2, k);
      wr_reg(2'h1, 8'h02);
      wr_reg(2'h3, 8'h80);
      fork
        i_ebtec_event_src.send(9);
        meas(164);
      join
      chk("event irqs", ir, 3);
      wr_reg(2'h3, 8'h00);
    end
    // pwm: width, buffered compare, active low, stop level
    m = $urandom_range(120, 255);
    wr_reg(2'h2, 8'h02);
    wr_reg(2'h1, m);
    wr_reg(2'h3, 8'hC1); // active-high pattern
    repeat (300) @(posedge clk);
    meas(256);
    chk("pwm width", hi, m);
    chk("pwm irqs", ir, 1);
    wait_pin(0);
    wait_pin(1);
    n = $urandom_range(20, 99);
    wr_reg(2'h1, n); // writes far apart
    rd_chk("cmp readback", 2'h1, n);
    repeat (100) @(posedge clk);
    chk("old cmp holds", pin, 1);
    wr_reg(2'h3, 8'hC3);
    repeat (300) @(posedge clk);
    meas(256);
    chk("low width", hi, 256 - n);
    wr_reg(2'h3, 8'h43);
    repeat (3) @(posedge clk);
    chk("stop inactive", pin, 1);
    print_verdict;
  end
endmodule // ebtec_timer_bench
